//--- hdl/ppr_pkg.sv
// Package of the peripheral pin select router: register map, field layout and resets.
// Assumes an 8-bit register port addressed by byte offsets.
package ppr_pkg;

  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PORT_CNT      = 3;
  localparam int unsigned PINS_PER_PORT = 8;
  localparam int unsigned PIN_CNT       = PORT_CNT * PINS_PER_PORT;
  localparam int unsigned SRC_CNT       = 40;
  localparam int unsigned SEL_W         = 6;
  localparam int unsigned CODE_W        = 7;

  // Register offsets.
  localparam logic [ADDR_W-1:0] LOCK_OFS    = 10'h200;
  localparam logic [ADDR_W-1:0] OUT_SEL_OFS = 10'h201;
  localparam logic [ADDR_W-1:0] IN_SEL_OFS  = 10'h23E;

  // Lock control fields and key values.
  localparam int unsigned      LOCK_FLAG_BIT = 0;
  localparam logic [7:0]       KEY_FIRST     = 8'h55;
  localparam logic [7:0]       KEY_SECOND    = 8'hAA;

  // Input select field layout.
  localparam int unsigned PORT_FIELD_LSB = 3;
  localparam int unsigned PIN_FIELD_LSB  = 0;
  localparam logic [2:0]  PORT_A_CODE    = 3'h0;
  localparam logic [2:0]  PORT_B_CODE    = 3'h1;
  localparam logic [2:0]  PORT_C_CODE    = 3'h2;

  // Output source codes.
  localparam logic [CODE_W-1:0] CODE_LATCH   = 7'h00;
  localparam logic [CODE_W-1:0] CODE_LAST    = 7'h28;
  localparam logic [CODE_W-1:0] CODE_I2C_SCL = 7'h21;
  localparam logic [CODE_W-1:0] CODE_I2C_SDA = 7'h22;

  // Reset values.
  localparam logic [CODE_W-1:0] OUT_SEL_RESET = 7'h00;
  localparam logic              LOCK_RESET    = 1'b0;

  typedef enum logic [1:0] {
    PPR_KEY_IDLE,
    PPR_KEY_FIRST,
    PPR_KEY_ARMED
  } ppr_key_e;

endpackage : ppr_pkg

//--- hdl/ppr_router.sv
// Peripheral pin select router: output source muxing per pin, input pin selection per
// peripheral input, and a key-protected selection lock.
// Assumes pins arrive asynchronously, peripherals and the register port run on mclk.
//
// Notes on behaviour
// - Each pin has its own output source code register choosing its driver.
// - Pin direction control keeps authority over the pin output driver except on pins set to an I2C code.
// - The I2C unit overrides pin direction when it selects a pin.
// - Code zero routes the latch; codes 1-8 logic cells and waveform outputs.
// - Codes 9 to 0x1A pick capture, PWM, UART and comparator outputs.
// - Codes 0x1B to 0x28 pick SPI, I2C, timer, oscillator, clock, modulator, guard.
// - The 14-pin variant routes sources only to ports A and C.
// - Lock flag resets to 0; selections are then freely writable.
// - While the lock flag is 1 all selection registers are locked.
// - Lock flag sets only right after writes 0x55 then 0xAA to lock control.
// - Clearing the lock flag needs the same two-write key sequence.
// - With one-way option 1 the flag sets once and never clears before reset.
// - With one-way option 0 the flag may set and clear repeatedly via keys.
// - Sleep never alters any selection value.
// - Power-on reset restores input defaults and clears output codes only.
// - Reset rst_n clears the lock flag; power-on reset alone does not.
// - Input select bits 5:3 choose port A, B or C.
// - Input select bits 2:0 choose the pin within the chosen port.
// - Power-on reset loads each input select with its fixed default.
// - Writes to selection registers while locked are ignored silently.
// - Output codes are 7 bits in 6:0 and reset to zero.
// - The lock flag lives in bit 0 of lock control.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps

module ppr_router
  import ppr_pkg::*;
#(
  parameter int unsigned                     IN_CNT    = 16,
  parameter bit                              IS_20_PIN = 1'b1,
  parameter logic [IN_CNT*ppr_pkg::SEL_W-1:0] IN_DEFAULT = '0
)
(
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          porRst_n,
  input  wire logic                          oneWayLockOption,
  input  wire logic [ppr_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [ppr_pkg::DATA_W-1:0]    regWrData,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [ppr_pkg::DATA_W-1:0]    regRdData,
  input  wire logic [ppr_pkg::PIN_CNT-1:0]   pinLatchValue,
  input  wire logic [ppr_pkg::PIN_CNT-1:0]   pinDirectionControl,
  input  wire logic [ppr_pkg::SRC_CNT:1]     periphOut,
  input  wire logic [1:0]                    i2cDriveEn,
  output logic      [ppr_pkg::PIN_CNT-1:0]   pinOut,
  output logic      [ppr_pkg::PIN_CNT-1:0]   pinOe_n,
  input  wire logic [ppr_pkg::PIN_CNT-1:0]   pinIn,
  output logic      [IN_CNT-1:0]             periphIn,
  output logic                               selectionLockFlag
);
  import ppr_pkg::*;

  localparam int unsigned IN_IDX_W = $clog2(IN_CNT);

  logic [CODE_W-1:0]  outSel_q [PIN_CNT];
  logic [SEL_W-1:0]   inSel_q  [IN_CNT];
  logic               lock_q;
  logic               lockDone_q;
  ppr_key_e           keyState_q;
  logic [PIN_CNT-1:0] pinMeta_q;
  logic [PIN_CNT-1:0] pinSync_q;
  logic [1:0]         oneWaySync_q;
  logic               oneWay;

  logic               lockHit;
  logic               outHit;
  logic               inHit;
  logic [ADDR_W-1:0]  outIdx;
  logic [ADDR_W-1:0]  inIdx;
  logic               selWrOk;
  logic               keyArmed;
  logic               lockReq;
  logic               lockWrArmed;
  logic               lockSetOk;
  logic               lockClrOk;

  // Pins come from outside mclk's domain and pass two flops before any use.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end
    else
    begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // The one-way option is a static level but is still synchronised, so a late
  // strap cannot reach the lock logic in the middle of a clock edge.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oneWaySync_q <= 2'h0;
    end
    else
    begin
      oneWaySync_q <= {oneWaySync_q[0], oneWayLockOption};
    end
  end

  assign oneWay = oneWaySync_q[1];

  // Address decode.
  // Writes that hit no register are dropped but still break a key sequence.
  assign outIdx  = regAddr - OUT_SEL_OFS;
  assign inIdx   = regAddr - IN_SEL_OFS;
  assign lockHit = (regAddr == LOCK_OFS);
  assign outHit  = (regAddr >= OUT_SEL_OFS) && (outIdx < ADDR_W'(PIN_CNT));
  assign inHit   = (regAddr >= IN_SEL_OFS) && (inIdx < ADDR_W'(IN_CNT));
  assign selWrOk = regWr && !lock_q;

  // Key sequence tracker; any other write breaks the sequence.
  // Reads leave it alone, and a repeated first key keeps it waiting for the second.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      keyState_q <= PPR_KEY_IDLE;
    end
    else if (regWr)
    begin
      case (keyState_q)
        PPR_KEY_IDLE:
          keyState_q <= (lockHit && regWrData == KEY_FIRST) ? PPR_KEY_FIRST : PPR_KEY_IDLE;
        PPR_KEY_FIRST:
          keyState_q <= (lockHit && regWrData == KEY_SECOND) ? PPR_KEY_ARMED
                      : (lockHit && regWrData == KEY_FIRST) ? PPR_KEY_FIRST : PPR_KEY_IDLE;
        PPR_KEY_ARMED:
          keyState_q <= (lockHit && regWrData == KEY_FIRST) ? PPR_KEY_FIRST : PPR_KEY_IDLE;
        default:
          keyState_q <= PPR_KEY_IDLE;
      endcase
    end
  end

  assign keyArmed = (keyState_q == PPR_KEY_ARMED);
  assign lockReq  = regWrData[LOCK_FLAG_BIT];

  assign lockWrArmed = regWr && lockHit && keyArmed;
  assign lockSetOk   = lockReq && !(oneWay && lockDone_q);
  assign lockClrOk   = !lockReq && !oneWay;

  // Lock flag; only the write right after the key pair may change it.
  // A refused set or clear leaves the flag as it was.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_q <= LOCK_RESET;
    end
    else if (lockWrArmed)
    begin
      if (lockSetOk)
      begin
        lock_q <= 1'b1;
      end
      else if (lockClrOk)
      begin
        lock_q <= 1'b0;
      end
    end
  end

  // Remembers that the flag was set since the last reset, for the one-way option.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lockDone_q <= 1'b0;
    end
    else if (lockWrArmed && lockSetOk)
    begin
      lockDone_q <= 1'b1;
    end
  end

  assign selectionLockFlag = lock_q;

  // Selection registers only reset on power-on; sleep has no path here.
  // Writes to them while locked are dropped without any error response.
  generate
    for (genvar p = 0; p < PIN_CNT; p++)
    begin : g_outSel
      always_ff @(posedge mclk or negedge porRst_n)
      begin
        if (!porRst_n)
        begin
          outSel_q[p] <= OUT_SEL_RESET;
        end
        else if (selWrOk && outHit && outIdx == ADDR_W'(p))
        begin
          outSel_q[p] <= regWrData[CODE_W-1:0];
        end
      end
    end

    for (genvar i = 0; i < IN_CNT; i++)
    begin : g_inSel
      always_ff @(posedge mclk or negedge porRst_n)
      begin
        if (!porRst_n)
        begin
          inSel_q[i] <= IN_DEFAULT[i*SEL_W +: SEL_W];
        end
        else if (selWrOk && inHit && inIdx == ADDR_W'(i))
        begin
          inSel_q[i] <= regWrData[SEL_W-1:0];
        end
      end
    end
  endgenerate

  // Register read data, valid in the cycle after the read strobe.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData <= '0;
    end
    else if (regRd)
    begin
      if (lockHit)
      begin
        regRdData <= DATA_W'({lock_q});
      end
      else if (outHit)
      begin
        regRdData <= DATA_W'(outSel_q[outIdx[4:0]]);
      end
      else if (inHit)
      begin
        regRdData <= DATA_W'(inSel_q[inIdx[IN_IDX_W-1:0]]);
      end
      else
      begin
        regRdData <= '0;
      end
    end
    else
    begin
      regRdData <= '0;
    end
  end

  // Output mux per pin.
  // Port B pins of the smaller package never leave the latch value.
  generate
    for (genvar p = 0; p < PIN_CNT; p++)
    begin : g_pinOut
      localparam bit PIN_ROUTABLE = IS_20_PIN || (p / PINS_PER_PORT != 1);
      logic [CODE_W-1:0] code;
      logic              srcValid;
      logic              isI2c;
      logic              drive;
      logic              outVal;

      assign code     = outSel_q[p];
      assign srcValid = PIN_ROUTABLE && code != CODE_LATCH && code <= CODE_LAST;
      assign isI2c    = srcValid && (code == CODE_I2C_SCL || code == CODE_I2C_SDA);
      assign outVal   = srcValid ? periphOut[code[5:0]] : pinLatchValue[p];
      // The clock code is odd, so the low code bit picks which enable applies.
      assign drive    = isI2c ? i2cDriveEn[code[0] ? 0 : 1]
                              : !pinDirectionControl[p];

      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pinOut[p] <= 1'b0;
        end
        else
        begin
          pinOut[p] <= outVal;
        end
      end

      // Enable follows the direction control except where the I2C unit owns the pin.
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pinOe_n[p] <= 1'b1;
        end
        else
        begin
          pinOe_n[p] <= !drive;
        end
      end
    end
  endgenerate

  // Input selection per peripheral input.
  // Port codes that name no port read as zero, so a bad code cannot pick up noise.
  generate
    for (genvar i = 0; i < IN_CNT; i++)
    begin : g_periphIn
      logic [2:0] portSel;
      logic [2:0] pinSel;
      logic       inVal;

      assign portSel = inSel_q[i][PORT_FIELD_LSB +: 3];
      assign pinSel  = inSel_q[i][PIN_FIELD_LSB +: 3];

      always_comb
      begin
        case (portSel)
          PORT_A_CODE: inVal = pinSync_q[pinSel];
          PORT_B_CODE: inVal = IS_20_PIN ? pinSync_q[PINS_PER_PORT + pinSel] : 1'b0;
          PORT_C_CODE: inVal = pinSync_q[2*PINS_PER_PORT + pinSel];
          default:     inVal = 1'b0;
        endcase
      end

      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          periphIn[i] <= 1'b0;
        end
        else
        begin
          periphIn[i] <= inVal;
        end
      end
    end
  endgenerate

endmodule : ppr_router

//--- dv/ppr_pin_model.sv
// Pin pad model: a pin shows the router's level while driven, else the outside level.
// Assumes pinOe_n low means the router drives the pin.
`timescale 1ns/1ps
module ppr_pin_model
(
  input  wire logic [23:0] pinOut,
  input  wire logic [23:0] pinOe_n,
  input  wire logic [23:0] extLevel,
  output logic      [23:0] pinIn
);
  // A driven bidirectional pin feeds its own level back to the input path.
  assign pinIn = (pinOe_n & extLevel) | (~pinOe_n & pinOut);
endmodule : ppr_pin_model

//--- dv/ppr_router_assertions.sv
// Checker for the pin select router: lock gating and register read timing.
// Assumes it is bound to the router and sees only its ports.
`timescale 1ns/1ps
module ppr_router_assertions
  import ppr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        oneWayLockOption,
  input wire logic [9:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdData,
  input wire logic [23:0] pinOe_n,
  input wire logic        selectionLockFlag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic keyA_q;
  logic keyB_q;
  wire  lockWr = regWr && regAddr == LOCK_OFS;
  // Remembers whether the last two writes were the key pair.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      keyA_q <= 1'b0;
      keyB_q <= 1'b0;
    end
    else if (regWr)
    begin
      keyA_q <= lockWr && regWrData == KEY_FIRST;
      keyB_q <= lockWr && regWrData == KEY_SECOND && keyA_q;
    end
  end
  key_gate_a: assert property ($changed(selectionLockFlag) |->
    $past(lockWr && keyB_q) && selectionLockFlag == $past(regWrData[0])) else $error("flag moved without key");
  one_way_a: assert property ($fell(selectionLockFlag) |-> !$past(oneWayLockOption, 3))
    else $error("flag cleared in one-way mode");
  lock_hold_a: assert property (!lockWr |=> $stable(selectionLockFlag))
    else $error("flag moved without lock write");
  reset_lock_a: assert property (disable iff (1'b0) !rst_n ##1 !rst_n |-> !selectionLockFlag && &pinOe_n)
    else $error("reset left flag or drivers on");
  read_idle_a: assert property (regRdData != 8'h00 |-> $past(regRd))
    else $error("read data outside read slot");
  lock_read_a: assert property ($past(regRd && regAddr == LOCK_OFS) |->
    regRdData[0] == $past(selectionLockFlag)) else $error("lock read wrong");
  out_width_a: assert property ($past(regRd && regAddr >= OUT_SEL_OFS && regAddr < IN_SEL_OFS) |->
    !regRdData[7]) else $error("output code wider than 7 bits");
  in_width_a: assert property ($past(regRd && regAddr >= IN_SEL_OFS) |-> regRdData[7:6] == 2'b00)
    else $error("input select wider than 6 bits");
endmodule : ppr_router_assertions

bind ppr_router ppr_router_assertions ppr_router_assertions_inst (.mclk, .rst_n, .oneWayLockOption, .regAddr,
  .regWrData, .regWr, .regRd, .regRdData, .pinOe_n, .selectionLockFlag);

//--- dv/ppr_router_tb.sv
// Bench for the pin select router: reference model compared at every read and pin check.
// Assumes the router, its checker and the pin pad model are compiled first.
`timescale 1ns/1ps
module ppr_router_tb;
  import ppr_pkg::*;
  localparam logic [23:0] DEF = 24'h5CE442;
  logic mclk = 0, rst_n = 0, porRst_n = 0, oneWayLockOption = 0, regWr = 0, regRd = 0, lockFlag, lk;
  logic [9:0] regAddr = '0;
  logic [7:0] regWrData = '0, regRdData;
  logic [23:0] lat = '0, dir = '1, ext = '0, pinOut, pinOe_n, pinIn;
  logic [40:1] pOut = '0;
  logic [1:0] i2c = '0;
  logic [3:0] periphIn;
  logic [15:0] lf = 16'h0034;
  logic [6:0] oSel [24];
  logic [5:0] iSel [4];
  int k, n_errors, n_checks, cyc;
  always #5 mclk = ~mclk;
  ppr_router #(.IN_CNT(4), .IS_20_PIN(1'b1), .IN_DEFAULT(DEF)) ppr_router_inst (.mclk, .rst_n, .porRst_n,
    .oneWayLockOption, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .pinLatchValue(lat),
    .pinDirectionControl(dir), .periphOut(pOut), .i2cDriveEn(i2c), .pinOut, .pinOe_n, .pinIn, .periphIn,
    .selectionLockFlag(lockFlag));
  ppr_pin_model ppr_pin_model_inst (.pinOut, .pinOe_n, .extLevel(ext), .pinIn);
  function logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd
  function logic [7:0] ev(input logic [9:0] a);
    if (a == LOCK_OFS) return {7'h00, lk};
    if (a >= OUT_SEL_OFS && a < OUT_SEL_OFS + 24) return {1'b0, oSel[a - OUT_SEL_OFS]};
    if (a >= IN_SEL_OFS && a < IN_SEL_OFS + 4) return {2'b00, iSel[a - IN_SEL_OFS]};
    return 8'h00;
  endfunction : ev
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task give_verdict();
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    regRd <= 0;
    regWr <= 1;
    regAddr <= a;
    regWrData <= d;
    if (a == LOCK_OFS)
    begin
      if (k == 2 && !(oneWayLockOption && !d[0])) lk = d[0];
      k = (k == 2) ? 0 : (d == KEY_FIRST) ? 1 : (k == 1 && d == KEY_SECOND) ? 2 : 0;
    end
    else
    begin
      k = 0;
      if (!lk && a >= OUT_SEL_OFS && a < OUT_SEL_OFS + 24) oSel[a - OUT_SEL_OFS] = d[6:0];
      if (!lk && a >= IN_SEL_OFS && a < IN_SEL_OFS + 4) iSel[a - IN_SEL_OFS] = d[5:0];
    end
  endtask : wr
  task rd(input logic [9:0] a);
    logic [7:0] e;
    e = ev(a);
    @(posedge mclk);
    regWr <= 0;
    regRd <= 1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 0;
    #1 chk("regRdData", 24'(regRdData), 24'(e));
  endtask : rd
  task sweep();
    for (int a = 'h1FF; a < 'h243; a++) rd(10'(a));
  endtask : sweep
  // Writes of the lock register are issued back to back, as with interrupts held off.
  task key(input logic [7:0] d);
    wr(LOCK_OFS, KEY_FIRST);
    wr(LOCK_OFS, KEY_SECOND);
    wr(LOCK_OFS, d);
  endtask : key
  task pins();
    logic [23:0] eo, eoe, lv;
    logic [3:0] ei;
    @(posedge mclk);
    regWr <= 0;
    lat <= 24'({rnd(), rnd()});
    dir <= 24'({rnd(), rnd()});
    ext <= 24'({rnd(), rnd()});
    pOut <= 40'({rnd(), rnd(), rnd()});
    i2c <= 2'(rnd());
    repeat (6) @(posedge mclk);
    #1;
    for (int p = 0; p < 24; p++)
    begin
      eo[p] = (oSel[p] >= 1 && oSel[p] <= 40) ? pOut[oSel[p]] : lat[p];
      eoe[p] = (oSel[p] == CODE_I2C_SCL) ? !i2c[0] : (oSel[p] == CODE_I2C_SDA) ? !i2c[1] : dir[p];
      lv[p] = eoe[p] ? ext[p] : eo[p];
    end
    for (int i = 0; i < 4; i++) ei[i] = (iSel[i][5:3] < 3) ? lv[iSel[i][5:3] * 8 + iSel[i][2:0]] : 1'b0;
    chk("pinOut", pinOut, eo);
    chk("pinOe_n", pinOe_n, eoe);
    chk("periphIn", 24'(periphIn), 24'(ei));
  endtask : pins
  task step();
    logic [15:0] r;
    logic [7:0] d;
    r = rnd();
    d = r[1] ? (r[0] ? r[15:8] : {7'h00, r[8]}) : (r[0] ? KEY_SECOND : KEY_FIRST);
    if (k == 2) d = {7'h00, r[9]};
    if (k == 1 && d == KEY_FIRST) d = KEY_SECOND;
    if (r[15:14] == 0) rd(LOCK_OFS);
    else wr(r[10] ? LOCK_OFS : r[11] ? OUT_SEL_OFS + 10'(r[15:12]) : IN_SEL_OFS + 10'(r[13:12]), d);
  endtask : step
  task rstDev(input logic por);
    @(posedge mclk);
    {regWr, regRd, rst_n, porRst_n} <= {3'b000, !por};
    repeat (12) @(posedge mclk);
    {rst_n, porRst_n} <= 2'b11;
    lk = 0;
    k = 0;
    for (int i = 0; i < 24 && por; i++) oSel[i] = 7'h00;
    for (int i = 0; i < 4 && por; i++) iSel[i] = DEF[6 * i +: 6];
    repeat (3) @(posedge mclk);
  endtask : rstDev
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  initial
  begin
    rstDev(1);
    sweep();
    for (int r = 0; r < 3; r++)
    begin
      for (int p = 0; p < 24; p++) wr(OUT_SEL_OFS + 10'(p), 8'(r * 24 + p + (rnd() & 16'h0080)));
      for (int i = 0; i < 4; i++) wr(IN_SEL_OFS + 10'(i), 8'(rnd()));
      wr(IN_SEL_OFS + 3, {2'b00, iSel[0]});
      sweep();
      repeat (2) pins();
    end
    key(8'h01);
    wr(OUT_SEL_OFS, 8'h05);
    wr(IN_SEL_OFS, 8'h3F);
    sweep();
    pins();
    repeat (400) step();
    sweep();
    pins();
    rstDev(0);
    sweep();
    oneWayLockOption <= 1;
    repeat (4) @(posedge mclk);
    for (int n = 0; n < 2; n++)
    begin
      key(8'h01);
      key(8'h00);
      rd(LOCK_OFS);
      rstDev(n[0]);
    end
    sweep();
    pins();
    give_verdict();
  end
endmodule : ppr_router_tb
